/* rtl/bwrtc_regs.svh */
`ifndef BWRTC_REGS_SVH
`define BWRTC_REGS_SVH

`define BWRTC_OFF_HUND    15'h0000
`define BWRTC_OFF_SEC     15'h0001
`define BWRTC_OFF_MIN     15'h0002
`define BWRTC_OFF_AL_MIN  15'h0003
`define BWRTC_OFF_HOUR    15'h0004
`define BWRTC_OFF_AL_HOUR 15'h0005
`define BWRTC_OFF_DAY     15'h0006
`define BWRTC_OFF_AL_DAY  15'h0007
`define BWRTC_OFF_DATE    15'h0008
`define BWRTC_OFF_MONTH   15'h0009
`define BWRTC_OFF_YEAR    15'h000a
`define BWRTC_OFF_CMD     15'h000b
`define BWRTC_OFF_WD_LO   15'h000c
`define BWRTC_OFF_WD_HI   15'h000d
`define BWRTC_OFF_USER    15'h000e
`define BWRTC_TOP_SMALL   15'h1fff
`define BWRTC_TOP_LARGE   15'h7fff

// writable bits; the rest read zero
`define BWRTC_MSK_HUND    8'hff
`define BWRTC_MSK_SEC     8'h7f
`define BWRTC_MSK_MIN     8'h7f
`define BWRTC_MSK_HOUR    8'h7f
`define BWRTC_MSK_DAY     8'h07
`define BWRTC_MSK_DATE    8'h3f
`define BWRTC_MSK_MONTH   8'hdf
`define BWRTC_MSK_YEAR    8'hff
`define BWRTC_MSK_AL_MIN  8'hff
`define BWRTC_MSK_AL_HOUR 8'hff
`define BWRTC_MSK_AL_DAY  8'h87

`define BWRTC_BIT_TE      7
`define BWRTC_BIT_IPSW    6
`define BWRTC_BIT_WAM     3
`define BWRTC_BIT_TDM     2
`define BWRTC_BIT_WAF     1
`define BWRTC_BIT_TDF     0
`define BWRTC_BIT_ALMSK   7
`define BWRTC_BIT_H12     6
`define BWRTC_BIT_PM      5
`define BWRTC_CMD_RST     8'h80

`define BWRTC_CLK_NS      10
`define BWRTC_TICK_NS     10000000
`define BWRTC_TICK_CYC    (`BWRTC_TICK_NS / `BWRTC_CLK_NS)
`define BWRTC_HOLDOFF_MS  200
`define BWRTC_HOLDOFF_CYC ((`BWRTC_HOLDOFF_MS * 1000000) / `BWRTC_CLK_NS)

`endif

/* rtl/bwrtc_pkg.sv */
package bwrtc_pkg;
	typedef struct packed {
		logic [7:0] hund;
		logic [7:0] sec;
		logic [7:0] min;
		logic [7:0] hour;
		logic [7:0] day;
		logic [7:0] date;
		logic [7:0] month;
		logic [7:0] year;
	} bwrtc_time_t;

	typedef struct packed {
		logic        ce_n;
		logic        oe_n;
		logic        we_n;
		logic [14:0] addr;
		logic [7:0]  data;
	} bwrtc_bus_t;
endpackage

/* rtl/bwrtc_top.sv */
`timescale 1ns/1ps
`include "bwrtc_regs.svh"
module bwrtc_top import bwrtc_pkg::*; #(
	parameter int unsigned TICK_CYC    = `BWRTC_TICK_CYC,
	parameter int unsigned HOLDOFF_CYC = `BWRTC_HOLDOFF_CYC,
	parameter bit          LARGE_OPT   = 1'b1
) (
	input  wire logic       clk,
	input  wire logic       sys_rst,
	input  wire logic       pwr_good,
	input  wire bwrtc_bus_t bus_pins,
	output logic [7:0]      data_lines_out,
	output logic            data_lines_oe,
	output logic            interrupt_out_first_out,
	output logic            interrupt_out_first_oe,
	output logic            interrupt_out_second_out,
	output logic            interrupt_out_second_oe
);

	function automatic logic [7:0] bcd_inc(input logic [7:0] v);
		if (v[3:0] == 4'h9)
			bcd_inc = {v[7:4] + 4'h1, 4'h0};
		else
			bcd_inc = {v[7:4], v[3:0] + 4'h1};
	endfunction

	// two-digit year: 00 is leap, correct from 2000 through 2099
	function automatic logic [7:0] last_day(input logic [7:0] mon, input logic [7:0] yr);
		logic leap;
		leap = ((yr[4] == 1'b0) && (yr[1:0] == 2'b00)) || ((yr[4] == 1'b1) && (yr[1:0] == 2'b10));
		case (mon[4:0])
			5'h02:   last_day = leap ? 8'h29 : 8'h28;
			5'h04,
			5'h06,
			5'h09,
			5'h11:   last_day = 8'h30;
			default: last_day = 8'h31;
		endcase
	endfunction

	function automatic logic [13:0] bcd4_bin(input logic [15:0] v);
		bcd4_bin = 14'(v[15:12]) * 14'd1000 + 14'(v[11:8]) * 14'd100 + 14'(v[7:4]) * 14'd10 + 14'(v[3:0]);
	endfunction

	bwrtc_bus_t  pin_m_r;
	bwrtc_bus_t  pin_s_r;
	logic        pg_m_r;
	logic        pg_s_r;
	logic [24:0] hold_cnt_r;
	logic        bus_en_r;
	logic [19:0] tick_cnt_r;
	logic        tick;
	logic [14:0] addr;
	logic        rd_now;
	logic        rd_q_r;
	logic        rd_start;
	logic        wr_now;
	logic        wr_q_r;
	logic        wr_commit;
	logic        touch;
	logic [7:0]  wdat;
	bwrtc_time_t tm_r;
	bwrtc_time_t ext_r;
	bwrtc_time_t nt;
	logic        min_roll;
	logic        day_roll;
	logic [7:0]  al_min_r;
	logic [7:0]  al_hour_r;
	logic [7:0]  al_day_r;
	logic [7:0]  wd_lo_r;
	logic [7:0]  wd_hi_r;
	logic [7:0]  cmd_r;
	logic [13:0] wd_set;
	logic [13:0] wd_cnt_r;
	logic        wd_reload_r;
	logic        wd_fire;
	logic        al_match;
	logic        tdf_set;
	logic        tdf_clr;
	logic        waf_clr;
	logic [7:0]  reg_rd;
	logic [7:0]  rd_data_r;
	logic        tod_irq;
	logic        wd_irq;
	logic        irq_first_r;
	logic        irq_second_r;
	logic [7:0]  mem [0:32767];

	// every strobe, address and data bit crosses together so a write sees consistent data
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			pin_m_r <= '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, addr: 15'h0000, data: 8'h00};
			pin_s_r <= '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, addr: 15'h0000, data: 8'h00};
			pg_m_r  <= 1'b0;
			pg_s_r  <= 1'b0;
		end else begin
			pin_m_r <= bus_pins;
			pin_s_r <= pin_m_r;
			pg_m_r  <= pwr_good;
			pg_s_r  <= pg_m_r;
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			hold_cnt_r <= 25'h0000000;
			bus_en_r   <= 1'b0;
		end else if (!pg_s_r) begin
			hold_cnt_r <= 25'h0000000;
			bus_en_r   <= 1'b0;
		end else if (hold_cnt_r == 25'(HOLDOFF_CYC - 1)) begin
			bus_en_r <= 1'b1;
		end else begin
			hold_cnt_r <= hold_cnt_r + 25'h0000001;
		end
	end

	// hundredth-second timebase runs regardless of power state
	always_ff @(posedge clk) begin
		if (sys_rst)
			tick_cnt_r <= 20'h00000;
		else if (tick)
			tick_cnt_r <= 20'h00000;
		else
			tick_cnt_r <= tick_cnt_r + 20'h00001;
	end
	assign tick = (tick_cnt_r == 20'(TICK_CYC - 1));

	// small option ignores the two top address lines
	assign addr = LARGE_OPT ? pin_s_r.addr : (pin_s_r.addr & `BWRTC_TOP_SMALL);
	assign rd_now = bus_en_r && !pin_s_r.ce_n && !pin_s_r.oe_n && pin_s_r.we_n;
	assign wr_now = bus_en_r && !pin_s_r.ce_n && !pin_s_r.we_n;
	assign wr_commit = wr_q_r && !wr_now && bus_en_r;
	assign rd_start  = rd_now && !rd_q_r;
	assign touch     = rd_start || wr_commit;
	assign wdat      = pin_s_r.data;

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			rd_q_r <= 1'b0;
			wr_q_r <= 1'b0;
		end else begin
			rd_q_r <= rd_now;
			wr_q_r <= wr_now;
		end
	end

	always_comb begin
		nt       = tm_r;
		min_roll = 1'b0;
		day_roll = 1'b0;
		nt.hund  = bcd_inc(tm_r.hund);
		if (tm_r.hund == 8'h99) begin
			nt.hund = 8'h00;
			nt.sec  = bcd_inc(tm_r.sec);
			if (tm_r.sec[6:0] == 7'h59) begin
				nt.sec   = 8'h00;
				min_roll = 1'b1;
				nt.min   = bcd_inc(tm_r.min);
				if (tm_r.min[6:0] == 7'h59) begin
					nt.min = 8'h00;
					if (tm_r.hour[`BWRTC_BIT_H12]) begin
						if (tm_r.hour[4:0] == 5'h11) begin
							nt.hour = {tm_r.hour[7:6], ~tm_r.hour[`BWRTC_BIT_PM], 5'h12};
							day_roll = tm_r.hour[`BWRTC_BIT_PM];
						end else if (tm_r.hour[4:0] == 5'h12) begin
							nt.hour = {tm_r.hour[7:5], 5'h01};
						end else begin
							nt.hour = {tm_r.hour[7:5], 5'(bcd_inc({3'b000, tm_r.hour[4:0]}))};
						end
					end else if (tm_r.hour[5:0] == 6'h23) begin
						nt.hour  = {tm_r.hour[7:6], 6'h00};
						day_roll = 1'b1;
					end else begin
						nt.hour = {tm_r.hour[7:6], 6'(bcd_inc({2'b00, tm_r.hour[5:0]}))};
					end
					if (day_roll) begin
						nt.day = (tm_r.day[2:0] == 3'h7) ? 8'h01 : bcd_inc(tm_r.day);
						if (tm_r.date[5:0] == last_day(tm_r.month, tm_r.year)) begin
							nt.date = 8'h01;
							if (tm_r.month[4:0] == 5'h12) begin
								nt.month = 8'h01;
								nt.year  = (tm_r.year == 8'h99) ? 8'h00 : bcd_inc(tm_r.year);
							end else begin
								nt.month = bcd_inc(tm_r.month);
							end
						end else begin
							nt.date = bcd_inc(tm_r.date);
						end
					end
				end
			end
		end
	end

	// weekday, hour, minute match with mask bits
	assign al_match = (al_min_r[`BWRTC_BIT_ALMSK] || (al_min_r[6:0] == nt.min[6:0])) &&
	                  (al_hour_r[`BWRTC_BIT_ALMSK] || (al_hour_r[6:0] == nt.hour[6:0])) &&
	                  (al_day_r[`BWRTC_BIT_ALMSK] || (al_day_r[2:0] == nt.day[2:0]));
	assign tdf_set  = tick && min_roll && al_match;

	// internal counters; a bus write also sets the running time
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			tm_r <= '{hund: 8'h00, sec: 8'h00, min: 8'h00, hour: 8'h00,
			          day: 8'h01, date: 8'h01, month: 8'h01, year: 8'h00};
		end else begin
			if (tick)
				tm_r <= nt;
			if (wr_commit) begin
				case (addr)
					`BWRTC_OFF_HUND:  tm_r.hund  <= wdat & `BWRTC_MSK_HUND;
					`BWRTC_OFF_SEC:   tm_r.sec   <= wdat & `BWRTC_MSK_SEC;
					`BWRTC_OFF_MIN:   tm_r.min   <= wdat & `BWRTC_MSK_MIN;
					`BWRTC_OFF_HOUR:  tm_r.hour  <= wdat & `BWRTC_MSK_HOUR;
					`BWRTC_OFF_DAY:   tm_r.day   <= wdat & `BWRTC_MSK_DAY;
					`BWRTC_OFF_DATE:  tm_r.date  <= wdat & `BWRTC_MSK_DATE;
					`BWRTC_OFF_MONTH: tm_r.month <= {3'b000, wdat[4:0]};
					`BWRTC_OFF_YEAR:  tm_r.year  <= wdat & `BWRTC_MSK_YEAR;
					default: ;
				endcase
			end
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			ext_r <= '{hund: 8'h00, sec: 8'h00, min: 8'h00, hour: 8'h00,
			           day: 8'h01, date: 8'h01, month: 8'h01, year: 8'h00};
		end else begin
			// one simultaneous transfer, frozen while transfer enable low
			if (tick && cmd_r[`BWRTC_BIT_TE])
				ext_r <= '{hund: nt.hund, sec: nt.sec, min: nt.min, hour: nt.hour, day: nt.day,
				           date: nt.date, month: {ext_r.month[7:6], nt.month[5:0]}, year: nt.year};
			if (wr_commit) begin
				case (addr)
					`BWRTC_OFF_HUND:  ext_r.hund  <= wdat & `BWRTC_MSK_HUND;
					`BWRTC_OFF_SEC:   ext_r.sec   <= wdat & `BWRTC_MSK_SEC;
					`BWRTC_OFF_MIN:   ext_r.min   <= wdat & `BWRTC_MSK_MIN;
					`BWRTC_OFF_HOUR:  ext_r.hour  <= wdat & `BWRTC_MSK_HOUR;
					`BWRTC_OFF_DAY:   ext_r.day   <= wdat & `BWRTC_MSK_DAY;
					`BWRTC_OFF_DATE:  ext_r.date  <= wdat & `BWRTC_MSK_DATE;
					`BWRTC_OFF_MONTH: ext_r.month <= wdat & `BWRTC_MSK_MONTH;
					`BWRTC_OFF_YEAR:  ext_r.year  <= wdat & `BWRTC_MSK_YEAR;
					default: ;
				endcase
			end
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			al_min_r  <= 8'h00;
			al_hour_r <= 8'h00;
			al_day_r  <= 8'h00;
			wd_lo_r   <= 8'h00;
			wd_hi_r   <= 8'h00;
		end else if (wr_commit) begin
			case (addr)
				`BWRTC_OFF_AL_MIN:  al_min_r  <= wdat & `BWRTC_MSK_AL_MIN;
				`BWRTC_OFF_AL_HOUR: al_hour_r <= wdat & `BWRTC_MSK_AL_HOUR;
				`BWRTC_OFF_AL_DAY:  al_day_r  <= wdat & `BWRTC_MSK_AL_DAY;
				`BWRTC_OFF_WD_LO:   wd_lo_r   <= wdat;
				`BWRTC_OFF_WD_HI:   wd_hi_r   <= wdat;
				default: ;
			endcase
		end
	end

	assign tdf_clr = touch && ((addr == `BWRTC_OFF_AL_MIN) || (addr == `BWRTC_OFF_AL_HOUR) ||
	                           (addr == `BWRTC_OFF_AL_DAY));
	assign waf_clr = touch && ((addr == `BWRTC_OFF_WD_LO) || (addr == `BWRTC_OFF_WD_HI));

	// countdown in hundredths; zero setting disables
	assign wd_set  = bcd4_bin({wd_hi_r, wd_lo_r});
	assign wd_fire = tick && !wd_reload_r && (wd_set != 14'h0000) && (wd_cnt_r <= 14'h0001);

	// reload one cycle after the access so a write's new value is used
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			wd_cnt_r    <= 14'h0000;
			wd_reload_r <= 1'b0;
		end else begin
			wd_reload_r <= waf_clr;
			if (wd_reload_r)
				wd_cnt_r <= wd_set;
			else if (wd_fire)
				wd_cnt_r <= wd_set;
			else if (tick && (wd_cnt_r != 14'h0000))
				wd_cnt_r <= wd_cnt_r - 14'h0001;
		end
	end

	// command register; hardware set wins over any clear
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			cmd_r <= `BWRTC_CMD_RST;
		end else begin
			if (wr_commit && (addr == `BWRTC_OFF_CMD))
				cmd_r <= wdat;
			if (tdf_clr)
				cmd_r[`BWRTC_BIT_TDF] <= 1'b0;
			if (waf_clr)
				cmd_r[`BWRTC_BIT_WAF] <= 1'b0;
			if (tdf_set)
				cmd_r[`BWRTC_BIT_TDF] <= 1'b1;
			if (wd_fire)
				cmd_r[`BWRTC_BIT_WAF] <= 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (wr_commit && (addr >= `BWRTC_OFF_USER))
			mem[addr] <= wdat;
	end

	// register window below the user bytes
	always_comb begin
		case (addr)
			`BWRTC_OFF_HUND:    reg_rd = ext_r.hund;
			`BWRTC_OFF_SEC:     reg_rd = ext_r.sec;
			`BWRTC_OFF_MIN:     reg_rd = ext_r.min;
			`BWRTC_OFF_AL_MIN:  reg_rd = al_min_r;
			`BWRTC_OFF_HOUR:    reg_rd = ext_r.hour;
			`BWRTC_OFF_AL_HOUR: reg_rd = al_hour_r;
			`BWRTC_OFF_DAY:     reg_rd = ext_r.day;
			`BWRTC_OFF_AL_DAY:  reg_rd = al_day_r;
			`BWRTC_OFF_DATE:    reg_rd = ext_r.date;
			`BWRTC_OFF_MONTH:   reg_rd = ext_r.month;
			`BWRTC_OFF_YEAR:    reg_rd = ext_r.year;
			`BWRTC_OFF_CMD:     reg_rd = cmd_r;
			`BWRTC_OFF_WD_LO:   reg_rd = wd_lo_r;
			`BWRTC_OFF_WD_HI:   reg_rd = wd_hi_r;
			default:            reg_rd = mem[addr];
		endcase
	end

	always_ff @(posedge clk) begin
		if (sys_rst)
			rd_data_r <= 8'h00;
		else
			rd_data_r <= reg_rd;
	end

	assign data_lines_out = rd_data_r;
	// drivers follow the read condition, so a falling write strobe releases them
	assign data_lines_oe  = rd_now && rd_q_r;

	// interrupts stay live with power out of tolerance
	assign tod_irq = cmd_r[`BWRTC_BIT_TDF] && !cmd_r[`BWRTC_BIT_TDM];
	assign wd_irq  = cmd_r[`BWRTC_BIT_WAF] && !cmd_r[`BWRTC_BIT_WAM];

	// level mode only; pins are open drain, pulled low while active
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			irq_first_r  <= 1'b0;
			irq_second_r <= 1'b0;
		end else begin
			irq_first_r  <= cmd_r[`BWRTC_BIT_IPSW] ? tod_irq : wd_irq;
			irq_second_r <= cmd_r[`BWRTC_BIT_IPSW] ? wd_irq : tod_irq;
		end
	end

	assign interrupt_out_first_out  = 1'b0;
	assign interrupt_out_first_oe   = irq_first_r;
	assign interrupt_out_second_out = 1'b0;
	assign interrupt_out_second_oe  = irq_second_r;

endmodule // bwrtc_top

/* sim/bwrtc_top_asserts.sv */
`timescale 1ns/1ps
module bwrtc_top_asserts import bwrtc_pkg::*; #(
	parameter int unsigned TICK_CYC    = 10,
	parameter int unsigned HOLDOFF_CYC = 8,
	parameter bit          LARGE_OPT   = 1'b1
) (
	input wire logic       clk,
	input wire logic       sys_rst,
	input wire logic       pwr_good,
	input wire bwrtc_bus_t bus_pins,
	input wire logic [7:0] data_lines_out,
	input wire logic       data_lines_oe,
	input wire logic       interrupt_out_first_out,
	input wire logic       interrupt_out_first_oe,
	input wire logic       interrupt_out_second_out,
	input wire logic       interrupt_out_second_oe
);
	logic rd_pin;
	logic wd_pin;
	logic al_pin;
	logic wr_q_r;
	logic ipsw_r;
	logic wd_oe;
	logic tod_oe;
	assign rd_pin = !bus_pins.ce_n && !bus_pins.oe_n && bus_pins.we_n;
	assign wd_pin = rd_pin && bus_pins.addr[14:1] == 14'h0006;
	assign al_pin = rd_pin && bus_pins.addr inside {15'h0003, 15'h0005, 15'h0007};
	assign wd_oe  = ipsw_r ? interrupt_out_second_oe : interrupt_out_first_oe;
	assign tod_oe = ipsw_r ? interrupt_out_first_oe : interrupt_out_second_oe;

	// pin routing follows the switch bit as last written over the bus
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			wr_q_r <= 1'b0;
			ipsw_r <= 1'b0;
		end else begin
			wr_q_r <= !bus_pins.ce_n && !bus_pins.we_n;
			if (wr_q_r && (bus_pins.ce_n || bus_pins.we_n) && pwr_good && (bus_pins.addr == 15'h000b))
				ipsw_r <= bus_pins.data[6];
		end
	end

	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);

	property p_rd_rise; $rose(data_lines_oe) |-> $past(rd_pin, 2); endproperty
	a_rd_rise: assert property (p_rd_rise) else $error("data driven without a read");
	property p_rd_end; (!rd_pin)[*5] |-> !data_lines_oe; endproperty
	a_rd_end: assert property (p_rd_end) else $error("data still driven after read");
	property p_we_off; $fell(bus_pins.we_n) && !bus_pins.ce_n && !bus_pins.oe_n |-> ##[1:5] !data_lines_oe;
	endproperty
	a_we_off: assert property (p_we_off) else $error("write strobe left drivers on");
	property p_wr_quiet; (!bus_pins.ce_n && !bus_pins.we_n)[*5] |-> !data_lines_oe; endproperty
	a_wr_quiet: assert property (p_wr_quiet) else $error("drivers on during write");
	property p_pwr; (!pwr_good)[*4] |-> !data_lines_oe; endproperty
	a_pwr: assert property (p_pwr) else $error("bus answered with power low");
	property p_hold; $rose(pwr_good) |-> (!data_lines_oe)[*8]; endproperty
	a_hold: assert property (p_hold) else $error("bus answered in hold-off");
	property p_wd_clr; wd_pin[*3] |-> ##[0:3] !wd_oe; endproperty
	a_wd_clr: assert property (p_wd_clr) else $error("watchdog access left irq");
	property p_al_clr; al_pin[*3] |-> ##[0:3] !tod_oe; endproperty
	a_al_clr: assert property (p_al_clr) else $error("alarm access left irq");

	c_rd: cover property ($rose(data_lines_oe));
	c_irq1: cover property ($rose(interrupt_out_first_oe));
	c_irq2: cover property ($rose(interrupt_out_second_oe));
endmodule // bwrtc_top_asserts

/* sim/bwrtc_host.sv */
`timescale 1ns/1ps
module bwrtc_host import bwrtc_pkg::*; (
	input  wire logic       clk,
	output bwrtc_bus_t      bus_pins,
	input  wire logic [7:0] data_lines_out,
	input  wire logic       data_lines_oe
);
	logic        ce_n = 1'b1;
	logic        oe_n = 1'b1;
	logic        we_n = 1'b1;
	logic        drv  = 1'b0;
	logic [14:0] adr  = 15'h0000;
	logic [7:0]  hd   = 8'h00;
	logic [7:0]  dq;
	logic [7:0]  last_r = 8'h00;
	// released lines toggle so a stale value never reads back
	assign dq = data_lines_oe ? data_lines_out : drv ? hd : ~last_r;
	assign bus_pins = {ce_n, oe_n, we_n, adr, dq};
	always_ff @(posedge clk) begin
		last_r <= dq;
	end

	task automatic wr(input logic [14:0] a, input logic [7:0] d);
		@(negedge clk);
		adr = a;
		hd = d;
		drv = 1'b1;
		oe_n = 1'b1;
		ce_n = 1'b0;
		we_n = 1'b0;
		repeat (4) @(negedge clk);
		ce_n = 1'b1;
		we_n = 1'b1;
		repeat (4) @(negedge clk);
		drv = 1'b0;
	endtask

	// brk lowers the write strobe into an open read; n counts cycles to drivers off
	task automatic rd(input logic [14:0] a, output logic [7:0] d, output logic got, input logic brk, output int n);
		d = 'x;
		got = 1'b0;
		n = 0;
		@(negedge clk);
		adr = a;
		ce_n = 1'b0;
		oe_n = 1'b0;
		for (int i = 0; i < 12 && !got; i++) begin
			@(negedge clk);
			if (data_lines_oe === 1'b1) begin
				got = 1'b1;
				d = data_lines_out;
			end
		end
		if (brk && got) begin
			hd = d;
			drv = 1'b1;
			we_n = 1'b0;
			while (data_lines_oe !== 1'b0 && n < 8) begin
				@(negedge clk);
				n++;
			end
			repeat (4) @(negedge clk);
		end
		ce_n = 1'b1;
		oe_n = 1'b1;
		we_n = 1'b1;
		repeat (4) @(negedge clk);
		drv = 1'b0;
	endtask
endmodule // bwrtc_host

/* sim/bwrtc_top_test.sv */
`timescale 1ns/1ps
module bwrtc_top_test import bwrtc_pkg::*;;
	logic        clk = 1'b0;
	logic        sys_rst = 1'b1;
	logic        pwr_good = 1'b0;
	bwrtc_bus_t  bus_pins;
	logic [7:0]  dq_o;
	logic        dq_oe, i1o, i1e, i2o, i2e, g;
	logic [7:0]  d, a0, b0;
	logic [14:0] ua [10];
	logic [7:0]  ud [10];
	int          err_total = 0, checked = 0, cyc = 0, n;

	bwrtc_top #(.TICK_CYC(10), .HOLDOFF_CYC(8), .LARGE_OPT(1'b1)) u_bwrtc_top (.clk(clk), .sys_rst(sys_rst),
		.pwr_good(pwr_good), .bus_pins(bus_pins), .data_lines_out(dq_o), .data_lines_oe(dq_oe),
		.interrupt_out_first_out(i1o), .interrupt_out_first_oe(i1e),
		.interrupt_out_second_out(i2o), .interrupt_out_second_oe(i2e));
	bwrtc_host u_bwrtc_host (.clk(clk), .bus_pins(bus_pins), .data_lines_out(dq_o), .data_lines_oe(dq_oe));

	initial forever #5 clk = ~clk;

	task automatic give_verdict();
		$display("mismatches %0d of %0d checks", err_total, checked);
		if (err_total == 0 && checked > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	always @(posedge clk) begin
		cyc++;
		if (cyc == 30000) begin
			err_total++;
			give_verdict();
		end
	end

	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		checked++;
		if (seen !== exp) begin
			err_total++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [14:0] a, input logic [7:0] v);
		u_bwrtc_host.wr(a, v);
	endtask
	task automatic rdv(input logic [14:0] a, output logic [7:0] v);
		u_bwrtc_host.rd(a, v, g, 1'b0, n);
	endtask
	task automatic rdc(input logic [14:0] a, input logic [7:0] exp);
		rdv(a, d);
		chk(d, exp);
	endtask

	function automatic logic [7:0] bcd(input int v);
		return 8'((v / 10) * 16 + v % 10);
	endfunction
	function automatic logic [7:0] binc(input logic [7:0] v);
		return (v == 8'h99) ? 8'h00 : (v[3:0] == 4'h9) ? {v[7:4] + 4'h1, 4'h0} : v + 8'h01;
	endfunction
	function automatic logic [7:0] mdays(input logic [7:0] mo, input logic [7:0] yr);
		case (mo)
			8'h02: return ((yr[7:4] * 10 + yr[3:0]) % 4 == 0) ? 8'h29 : 8'h28;
			8'h04, 8'h06, 8'h09, 8'h11: return 8'h30;
			default: return 8'h31;
		endcase
	endfunction

	// last tick of a month; hundredths set last so nothing rolls early
	task automatic roll(input logic [7:0] mo, input logic [7:0] yr, input logic [7:0] hr);
		wr(15'h0000, 8'h00);
		wr(15'h000a, yr);
		wr(15'h0009, mo);
		wr(15'h0008, mdays(mo, yr));
		wr(15'h0004, hr);
		wr(15'h0002, 8'h59);
		wr(15'h0001, 8'h59);
		wr(15'h0000, 8'h99);
		repeat (30) @(negedge clk);
		rdc(15'h0008, 8'h01);
		rdc(15'h0009, (mo == 8'h12) ? 8'h01 : binc(mo));
		rdc(15'h000a, (mo == 8'h12) ? binc(yr) : yr);
		rdc(15'h0004, hr[6] ? 8'h52 : 8'h00);
		rdc(15'h0002, 8'h00);
	endtask

	initial begin
		void'($urandom(90));
		repeat (12) @(negedge clk);
		sys_rst = 1'b0;
		pwr_good = 1'b1;
		repeat (20) @(negedge clk);
		rdc(15'h000b, 8'h80);
		rdc(15'h0009, 8'h01);
		rdc(15'h000a, 8'h00);
		rdc(15'h0003, 8'h00);
		rdc(15'h000d, 8'h00);
		ua[0] = 15'h000e;
		ua[1] = 15'h7fff;
		for (int i = 0; i < 10; i++) begin
			if (i > 1)
				// one band per entry so no two bytes alias
				ua[i] = 15'h000e + 15'(i * 3000 + $urandom % 3000);
			ud[i] = 8'($urandom);
			wr(ua[i], ud[i]);
		end
		for (int i = 0; i < 10; i++)
			rdc(ua[i], ud[i]);
		u_bwrtc_host.rd(ua[2], d, g, 1'b1, n);
		chk(8'(n <= 5), 8'h01);
		rdc(ua[2], ud[2]);
		roll(8'h02, 8'h04, 8'h23);
		roll(8'h02, 8'h01, 8'h71);
		roll(8'h12, 8'h99, 8'h23);
		repeat (4) roll(bcd($urandom % 12 + 1), bcd($urandom % 100), ($urandom % 2) ? 8'h71 : 8'h23);
		// 12-hour step inside the morning: 09 AM to 10 AM
		wr(15'h0000, 8'h00);
		wr(15'h0004, 8'h49);
		wr(15'h0002, 8'h59);
		wr(15'h0001, 8'h59);
		wr(15'h0000, 8'h99);
		repeat (30) @(negedge clk);
		rdc(15'h0004, 8'h50);
		// watchdog of two hundredths, first pin while the switch bit is low
		wr(15'h000c, 8'h02);
		wr(15'h000d, 8'h00);
		for (n = 0; n < 100 && i1e !== 1'b1; n++) @(negedge clk);
		chk({6'h0, i1e, i2e}, 8'h02);
		rdc(15'h000b, 8'h82);
		rdc(15'h000c, 8'h02);
		chk({7'h0, i1e}, 8'h00);
		wr(15'h000b, 8'hc0);
		for (n = 0; n < 100 && i2e !== 1'b1; n++) @(negedge clk);
		chk({6'h0, i1e, i2e}, 8'h01);
		wr(15'h000c, 8'h00);
		wr(15'h000d, 8'h00);
		repeat (100) @(negedge clk);
		chk({6'h0, i1e, i2e}, 8'h00);
		wr(15'h000b, 8'h40);
		rdv(15'h0000, a0);
		repeat (50) @(negedge clk);
		rdv(15'h0000, b0);
		chk(b0, a0);
		wr(15'h000b, 8'hc0);
		rdv(15'h0000, a0);
		repeat (50) @(negedge clk);
		rdv(15'h0000, b0);
		chk(8'(a0 !== b0), 8'h01);
		// every mask bit set: alarm on the next minute rollover, first pin with switch high
		wr(15'h0003, 8'h80);
		wr(15'h0005, 8'h80);
		wr(15'h0007, 8'h80);
		wr(15'h0001, 8'h59);
		wr(15'h0000, 8'h99);
		for (n = 0; n < 100 && i1e !== 1'b1; n++) @(negedge clk);
		chk({6'h0, i1e, i2e}, 8'h02);
		chk({6'h0, i1o, i2o}, 8'h00);
		rdc(15'h000b, 8'hc1);
		rdc(15'h0003, 8'h80);
		chk({6'h0, i1e, i2e}, 8'h00);
		pwr_good = 1'b0;
		repeat (5) @(negedge clk);
		wr(ua[3], ~ud[3]);
		rdv(ua[3], d);
		chk({7'h0, g}, 8'h00);
		pwr_good = 1'b1;
		repeat (20) @(negedge clk);
		rdc(ua[3], ud[3]);
		wr(15'h0006, 8'hff);
		rdc(15'h0006, 8'h07);
		wr(15'h0007, 8'hff);
		rdc(15'h0007, 8'h87);
		give_verdict();
	end
endmodule // bwrtc_top_test

bind bwrtc_top bwrtc_top_asserts #(.TICK_CYC(TICK_CYC), .HOLDOFF_CYC(HOLDOFF_CYC), .LARGE_OPT(LARGE_OPT))
	u_bwrtc_top_asserts (.clk(clk), .sys_rst(sys_rst), .pwr_good(pwr_good), .bus_pins(bus_pins),
	.data_lines_out(data_lines_out), .data_lines_oe(data_lines_oe),
	.interrupt_out_first_out(interrupt_out_first_out), .interrupt_out_first_oe(interrupt_out_first_oe),
	.interrupt_out_second_out(interrupt_out_second_out), .interrupt_out_second_oe(interrupt_out_second_oe));
